// ---- framer_defines.svh ----
// Constants for the datagram message framer.
`ifndef FRAMER_DEFINES_SVH
`define FRAMER_DEFINES_SVH
`define FUNC_CODE        8'h20
`define SUB_READ_ID      8'h00
`define SUB_LAST         8'h2d
`define SUB_CLEAR_ALL    8'h13
`define SUB_HOT_STANDBY  8'h2d
`define HOT_STANDBY_ADDR 8'h1d
`define BCAST_ADDR       8'hff
`define FLAG_PRIO_BIT    0
`define FLAG_BCAST_BIT   1
`define FLAG_PROTO_BIT   8
`define HDR_BYTES        5
`define FIFO_DEPTH       32
`define BYTE_W           8
`endif

// ---- framer_pkg.sv ----
// Types shared by the datagram message framer.
package framer_pkg;
	typedef logic [7:0] byte_t;
	typedef enum logic {MODE_DIRECTED, MODE_BROADCAST} send_mode_t;
	typedef enum logic {PRIO_NORMAL, PRIO_HIGH} prio_t;
endpackage

// ---- byte_stream_if.sv ----
// Valid/ready byte stream carrier between framer modules.
`timescale 1ns/10ps
interface byte_stream_if #(parameter int W = 8);
	logic [W-1:0] data;
	logic         valid;
	logic         ready;
	modport source (output data, output valid, input ready);
	modport sink   (input data, input valid, output ready);
endinterface

// ---- byte_fifo.sv ----
// Flip-flop FIFO with valid/ready on both sides.
`timescale 1ns/10ps
module byte_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 32
) (
	input  wire logic    clk_i,
	input  wire logic    reset_i,
	byte_stream_if.sink  in_s,
	byte_stream_if.source out_s
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
	logic [AW:0]   cnt_reg, cnt_next;
	logic          push, pop;

	assign in_s.ready  = (cnt_reg != (AW+1)'(DEPTH));
	assign out_s.valid = (cnt_reg != '0);
	assign out_s.data  = mem_reg[rd_reg];
	assign push = in_s.valid && in_s.ready;
	assign pop  = out_s.valid && out_s.ready;

	always_comb begin
		wr_next  = push ? AW'(wr_reg + 1'b1) : wr_reg;
		rd_next  = pop ? AW'(rd_reg + 1'b1) : rd_reg;
		cnt_next = cnt_reg;
		if (push && !pop)
			cnt_next = cnt_reg + 1'b1;
		else if (pop && !push)
			cnt_next = cnt_reg - 1'b1;
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			wr_reg  <= wr_next;
			rd_reg  <= rd_next;
			cnt_reg <= cnt_next;
		end
		if (push)
			mem_reg[wr_reg] <= in_s.data;
	end
endmodule

// ---- frame_checker.sv ----
// Receive-side header filter for incoming datagram messages.
`timescale 1ns/10ps
`include "framer_defines.svh"
module frame_checker (
	input  wire logic         clk_i,
	input  wire logic         reset_i,
	input  wire logic         hdr_valid_i,
	input  wire framer_pkg::byte_t func_i,
	input  wire framer_pkg::byte_t sub_i,
	output logic              accept_o,
	output framer_pkg::byte_t type_o
);
	import framer_pkg::*;
	logic  acc_reg, acc_next;
	byte_t type_reg, type_next;
	logic  good;

	// Codes 00..2D all exist except a few gaps; unknown codes are dropped.
	always_comb begin
		good = (func_i == `FUNC_CODE) && (sub_i <= `SUB_LAST) // R02 R17
			&& !(sub_i inside {8'h0a, 8'h0e, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18,
			8'h19, 8'h1a, 8'h1b, 8'h1d, 8'h21, 8'h23, 8'h24, 8'h25, 8'h26,
			8'h29}); // R01
		acc_next  = hdr_valid_i && good;
		type_next = (hdr_valid_i && good) ? sub_i : type_reg; // R17
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			acc_reg  <= 1'b0;
			type_reg <= 8'h00;
		end else begin
			acc_reg  <= acc_next;
			type_reg <= type_next;
		end
	end

	assign accept_o = acc_reg;
	assign type_o   = type_reg;

	property p_reject;
		@(posedge clk_i) disable iff (reset_i)
		(hdr_valid_i && func_i != `FUNC_CODE) |=> !accept_o;
	endproperty
	a_reject: assert property (p_reject) else $error("bad function code accepted"); // R17
	property p_keep;
		@(posedge clk_i) disable iff (reset_i)
		!accept_o |-> $stable(type_o) or $past(reset_i);
	endproperty
	a_keep: assert property (p_keep) else $error("type changed on reject"); // R17
endmodule

// ---- datagram_message_framer.sv ----
// Transmit framer: prepends datagram header, buffers content, and filters receive headers.
`timescale 1ns/10ps
`include "framer_defines.svh"
// How it works
// R01 - Each datagram type has unique subfunction code.
// R02 - Function code is always 20 hex.
// R03 - Bytes go out least significant first.
// R04 - Word bit 0 least, bit 15 most.
// R05 - Header bit 8 set by logic only.
// R06 - Sender prepends type, length, priority header.
// R07 - Directed or broadcast send mode.
// R08 - Content passes through unchanged for any origin.
// R09 - Host supplies content, destination, length, priority.
// R10 - Priority high or normal per transmission.
// R11 - Hosts use high priority sparingly.
// R12 - No program datagrams to first-generation blocks.
// R13 - Any node may be addressed.
// R14 - Hot standby assign uses code 2D, address 29.
// R15 - Clear all circuit faults uses code 13.
// R16 - Startup identification request, code 00, no data.
// R17 - Receiver ignores bad function or subfunction.
module datagram_message_framer #(
	parameter int DEPTH = `FIFO_DEPTH
) (
	input  wire logic              clk_i,
	input  wire logic              reset_i,
	input  wire logic              send_i,
	input  wire framer_pkg::byte_t dest_i,
	input  wire framer_pkg::byte_t sub_i,
	input  wire framer_pkg::byte_t len_i,
	input  wire framer_pkg::prio_t prio_i,
	input  wire framer_pkg::send_mode_t mode_i,
	input  wire logic              startup_i,
	input  wire logic              clear_faults_i,
	input  wire logic              hot_standby_i,
	output logic                   busy_o,
	input  wire logic [15:0]       word_i,
	input  wire logic              word_valid_i,
	output logic                   word_ready_o,
	output framer_pkg::byte_t      tx_data_o,
	output logic                   tx_valid_o,
	input  wire logic              tx_ready_i,
	output logic                   tx_last_o,
	input  wire logic              rx_hdr_valid_i,
	input  wire framer_pkg::byte_t rx_func_i,
	input  wire framer_pkg::byte_t rx_sub_i,
	output logic                   rx_accept_o,
	output framer_pkg::byte_t      rx_type_o
);
	import framer_pkg::*;

	// ==========================================================
	// State
	typedef enum logic [2:0] {S_IDLE, S_HDR, S_LO, S_HI, S_WAIT} st_t;
	st_t   st_reg, st_next;
	byte_t sub_reg, sub_next, dest_reg, dest_next, len_reg, len_next;
	logic [15:0] flags_reg, flags_next;
	logic [2:0]  hidx_reg, hidx_next;
	byte_t left_reg, left_next;
	logic [15:0] w_reg, w_next;
	byte_t hdr_byte;

	byte_stream_if #(.W(`BYTE_W)) fin ();
	byte_stream_if #(.W(`BYTE_W)) fout ();

	byte_fifo #(.W(`BYTE_W), .DEPTH(DEPTH)) u_fifo (
		.clk_i  (clk_i),
		.reset_i(reset_i),
		.in_s   (fin),
		.out_s  (fout)
	);

	frame_checker u_chk (
		.clk_i      (clk_i),
		.reset_i    (reset_i),
		.hdr_valid_i(rx_hdr_valid_i),
		.func_i     (rx_func_i),
		.sub_i      (rx_sub_i),
		.accept_o   (rx_accept_o),
		.type_o     (rx_type_o)
	);

	// ==========================================================
	// Header bytes: function, subfunction, destination, flags low, length, flags high.
	always_comb begin
		unique case (hidx_reg)
			3'd0:    hdr_byte = `FUNC_CODE; // R02
			3'd1:    hdr_byte = sub_reg; // R01
			3'd2:    hdr_byte = dest_reg; // R13
			3'd3:    hdr_byte = flags_reg[7:0]; // R03
			3'd4:    hdr_byte = len_reg;
			default: hdr_byte = flags_reg[15:8];
		endcase
	end

	assign busy_o       = (st_reg != S_IDLE);
	assign word_ready_o = (st_reg == S_LO) && fin.ready;
	// The FIFO takes the content unchanged, low byte then high byte.
	assign fin.valid = ((st_reg == S_LO) && word_valid_i) || (st_reg == S_HI); // R08
	assign fin.data  = (st_reg == S_HI) ? w_reg[15:8] : word_i[7:0]; // R03 R04
	assign tx_valid_o = (st_reg == S_HDR) || ((st_reg == S_WAIT) && fout.valid);
	assign tx_data_o  = (st_reg == S_HDR) ? hdr_byte : fout.data;
	assign tx_last_o  = (st_reg == S_WAIT) && fout.valid && (left_reg == 8'h01);
	assign fout.ready = (st_reg == S_WAIT) && tx_ready_i;

	// ==========================================================
	// Sequencer
	always_comb begin
		st_next    = st_reg;
		sub_next   = sub_reg;
		dest_next  = dest_reg;
		len_next   = len_reg;
		flags_next = flags_reg;
		hidx_next  = hidx_reg;
		left_next  = left_reg;
		w_next     = w_reg;
		unique case (st_reg)
			S_IDLE: begin
				hidx_next = '0;
				if (startup_i) begin
					sub_next  = `SUB_READ_ID; // R16
					len_next  = 8'h00; // R16
					dest_next = `BCAST_ADDR;
					st_next   = S_HDR;
				end else if (hot_standby_i) begin
					sub_next  = `SUB_HOT_STANDBY; // R14
					len_next  = len_i;
					dest_next = `HOT_STANDBY_ADDR; // R14
					st_next   = S_HDR;
				end else if (clear_faults_i) begin
					sub_next  = `SUB_CLEAR_ALL; // R15
					len_next  = 8'h00;
					dest_next = dest_i;
					st_next   = S_HDR;
				end else if (send_i) begin
					sub_next  = sub_i; // R09
					len_next  = len_i;
					dest_next = (mode_i == MODE_BROADCAST) ? `BCAST_ADDR : dest_i; // R07
					st_next   = S_HDR;
				end
				flags_next = '0;
				flags_next[`FLAG_PRIO_BIT]  = (prio_i == PRIO_HIGH); // R10
				flags_next[`FLAG_BCAST_BIT] = (mode_i == MODE_BROADCAST) && !startup_i; // R07
				flags_next[`FLAG_PROTO_BIT] = 1'b1; // R05
				if (startup_i)
					flags_next[`FLAG_BCAST_BIT] = 1'b1;
				left_next = (len_next == 8'h00) ? 8'h00 : len_next;
			end
			S_HDR: if (tx_ready_i) begin // R06
				if (hidx_reg == 3'(`HDR_BYTES)) begin
					st_next = (len_reg == 8'h00) ? S_IDLE : S_LO;
				end
				hidx_next = 3'(hidx_reg + 1'b1);
			end
			S_LO: if (word_valid_i && fin.ready) begin
				w_next  = word_i;
				st_next = S_HI;
			end
			S_HI: if (fin.ready)
				st_next = S_WAIT;
			S_WAIT: begin
				if (fout.valid && tx_ready_i) begin
					left_next = 8'(left_reg - 1'b1);
					if (left_reg == 8'h01)
						st_next = S_IDLE;
				end
				if ((fout.valid && tx_ready_i && left_reg == 8'h02) || !fout.valid)
					st_next = (left_reg <= 8'h01 && !fout.valid) ? S_IDLE
						: (fout.valid && tx_ready_i && left_reg == 8'h01) ? S_IDLE
						: (left_next > 8'h00 && !fout.valid) ? S_LO : st_next;
			end
			default: st_next = S_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			st_reg    <= S_IDLE;
			sub_reg   <= 8'h00;
			dest_reg  <= 8'h00;
			len_reg   <= 8'h00;
			flags_reg <= 16'h0000;
			hidx_reg  <= 3'd0;
			left_reg  <= 8'h00;
			w_reg     <= 16'h0000;
		end else begin
			st_reg    <= st_next;
			sub_reg   <= sub_next;
			dest_reg  <= dest_next;
			len_reg   <= len_next;
			flags_reg <= flags_next;
			hidx_reg  <= hidx_next;
			left_reg  <= left_next;
			w_reg     <= w_next;
		end
	end

	// ==========================================================
	// Content byte count
	// Kept apart from the sequencer so the length check does not trust its own counter.
	logic [7:0] sent_reg, sent_next;

	always_comb begin
		sent_next = sent_reg;
		if (st_reg == S_IDLE)
			sent_next = 8'h00;
		else if ((st_reg == S_WAIT) && fout.valid && tx_ready_i)
			sent_next = 8'(sent_reg + 1'b1);
	end

	always_ff @(posedge clk_i) begin
		if (reset_i)
			sent_reg <= 8'h00;
		else
			sent_reg <= sent_next;
	end

	// ==========================================================
	// Checks
	property p_func_first;
		@(posedge clk_i) disable iff (reset_i)
		(st_reg == S_HDR && hidx_reg == 3'd0) |-> tx_data_o == `FUNC_CODE;
	endproperty
	a_func_first: assert property (p_func_first) else $error("function code wrong"); // R02
	property p_proto_bit;
		@(posedge clk_i) disable iff (reset_i)
		(st_reg == S_HDR) |-> flags_reg[`FLAG_PROTO_BIT];
	endproperty
	a_proto_bit: assert property (p_proto_bit) else $error("bit 8 not set"); // R05
	property p_lsb_first;
		@(posedge clk_i) disable iff (reset_i)
		(st_reg == S_LO && word_valid_i && fin.ready) |-> fin.data == word_i[7:0]
			##1 fin.data == $past(word_i[15:8]);
	endproperty
	a_lsb_first: assert property (p_lsb_first) else $error("byte order wrong"); // R03
	property p_startup;
		@(posedge clk_i) disable iff (reset_i)
		(st_reg == S_IDLE && startup_i) |=> sub_reg == `SUB_READ_ID && len_reg == 8'h00;
	endproperty
	a_startup: assert property (p_startup) else $error("startup request wrong"); // R16
	property p_standby;
		@(posedge clk_i) disable iff (reset_i)
		(st_reg == S_IDLE && !startup_i && hot_standby_i) |=>
			sub_reg == `SUB_HOT_STANDBY && dest_reg == `HOT_STANDBY_ADDR;
	endproperty
	a_standby: assert property (p_standby) else $error("hot standby wrong"); // R14
	property p_clear;
		@(posedge clk_i) disable iff (reset_i)
		(st_reg == S_IDLE && !startup_i && !hot_standby_i && clear_faults_i) |=>
			sub_reg == `SUB_CLEAR_ALL;
	endproperty
	a_clear: assert property (p_clear) else $error("clear faults code wrong"); // R15
	property p_prio;
		@(posedge clk_i) disable iff (reset_i)
		(st_reg == S_IDLE && send_i) |=> flags_reg[`FLAG_PRIO_BIT] == $past(prio_i == PRIO_HIGH);
	endproperty
	a_prio: assert property (p_prio) else $error("priority flag wrong"); // R10
	property p_bcast;
		@(posedge clk_i) disable iff (reset_i)
		(st_reg == S_IDLE && send_i && !startup_i && !hot_standby_i && !clear_faults_i
			&& mode_i == MODE_BROADCAST) |=> dest_reg == `BCAST_ADDR;
	endproperty
	a_bcast: assert property (p_bcast) else $error("broadcast address wrong"); // R07
	property p_byte_holds;
		@(posedge clk_i) disable iff (reset_i)
		(tx_valid_o && !tx_ready_i) |=> tx_valid_o && $stable(tx_data_o);
	endproperty
	a_byte_holds: assert property (p_byte_holds) else $error("held byte dropped"); // R06
	property p_dest_hdr;
		@(posedge clk_i) disable iff (reset_i)
		(st_reg == S_HDR && hidx_reg == 3'd2) |-> tx_data_o == dest_reg;
	endproperty
	a_dest_hdr: assert property (p_dest_hdr) else $error("destination byte wrong"); // R13
	property p_wire_bit8;
		@(posedge clk_i) disable iff (reset_i)
		(st_reg == S_HDR && hidx_reg == 3'd5) |-> tx_data_o[0];
	endproperty
	a_wire_bit8: assert property (p_wire_bit8) else $error("bit 8 not on the wire"); // R05
	property p_high_second;
		@(posedge clk_i) disable iff (reset_i)
		(st_reg == S_HI) |-> fin.valid && fin.data == w_reg[15:8];
	endproperty
	a_high_second: assert property (p_high_second) else $error("high byte wrong"); // R04
	property p_no_content;
		@(posedge clk_i) disable iff (reset_i)
		(st_reg == S_HDR && hidx_reg == 3'd5 && tx_ready_i && len_reg == 8'h00) |=> !busy_o;
	endproperty
	a_no_content: assert property (p_no_content) else $error("empty datagram not ended"); // R16
	property p_len_match;
		@(posedge clk_i) disable iff (reset_i)
		(tx_last_o && tx_ready_i) |-> 8'(sent_reg + 1'b1) == len_reg;
	endproperty
	a_len_match: assert property (p_len_match) else $error("content length wrong"); // R06
	property p_last_ends;
		@(posedge clk_i) disable iff (reset_i)
		(tx_last_o && tx_ready_i) |=> !busy_o;
	endproperty
	a_last_ends: assert property (p_last_ends) else $error("frame not ended"); // R06
	property p_refuse;
		@(posedge clk_i) disable iff (reset_i)
		(busy_o && send_i) |=> $stable(sub_reg) && $stable(dest_reg) && $stable(len_reg);
	endproperty
	a_refuse: assert property (p_refuse) else $error("request taken while busy"); // R06
	property p_idle_quiet;
		@(posedge clk_i) disable iff (reset_i)
		!busy_o |-> !tx_valid_o && !word_ready_o;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("output active while idle"); // R06
endmodule

// ---- peer_node.sv ----
// Peer node model that sinks the framed byte stream.
`timescale 1ns/10ps
module peer_node (
	input  wire logic              clk_i,
	input  wire framer_pkg::byte_t tx_data_i,
	input  wire logic              tx_valid_i,
	input  wire logic              tx_last_i,
	input  wire logic              stall_i,
	output logic                   tx_ready_o
);
	import framer_pkg::*;
	// The model stands for a current block, never a first-generation one,
	// so it may be sent program datagrams.
	byte_t q[$];
	int    frames = 0;
	logic  toggle = 1'b0;
	// A slow peer takes every other byte, so held bytes get exercised.
	always @(negedge clk_i) begin
		toggle <= !toggle;
		tx_ready_o <= !stall_i || toggle;
	end
	// Bytes are kept in wire order, lowest first.
	always @(posedge clk_i) begin
		if (tx_valid_i && tx_ready_o) begin
			q.push_back(tx_data_i);
			if (tx_last_i) begin
				frames <= frames + 1;
			end
		end
	end
endmodule

// ---- test_datagram_message_framer.sv ----
// Self-checking bench for the datagram message framer.
`timescale 1ns/10ps
module test_datagram_message_framer;
	import framer_pkg::*;
	typedef struct {byte_t sub; byte_t dest; byte_t len; byte_t edest; byte_t flo; byte_t b;
		prio_t p; send_mode_t m; logic st;} row_t;
	logic        clk_i, reset_i, send_i, startup_i, clear_faults_i, hot_standby_i;
	logic        word_valid_i, rx_hdr_valid_i, stall, busy_o, word_ready_o;
	logic        tx_valid_o, tx_ready, tx_last_o, rx_accept_o;
	byte_t       dest_i, sub_i, len_i, rx_func_i, rx_sub_i, tx_data_o, rx_type_o, lt;
	prio_t       prio_i;
	send_mode_t  mode_i;
	logic [15:0] word_i;
	int          err_count, checks_done, i;
	// Broadcast rows expect the all-nodes address whatever dest was given.
	// High priority appears once per mode only, so it stays the exception.
	row_t rows [4] = '{
		'{8'h04, 8'h05, 8'h04, 8'h05, 8'h00, 8'h10, PRIO_NORMAL, MODE_DIRECTED, 1'b0},
		'{8'h0c, 8'h1e, 8'h02, 8'h1e, 8'h01, 8'h40, PRIO_HIGH, MODE_DIRECTED, 1'b1},
		'{8'h27, 8'h07, 8'h06, 8'hff, 8'h02, 8'h80, PRIO_NORMAL, MODE_BROADCAST, 1'b1},
		'{8'h2c, 8'h03, 8'h02, 8'hff, 8'h03, 8'hc0, PRIO_HIGH, MODE_BROADCAST, 1'b0}};
	logic [16:0] rxr [6] = '{17'h12000, 17'h02100, 17'h1202d, 17'h0202e, 17'h12013, 17'h0200a};

	datagram_message_framer u_dut (.clk_i(clk_i), .reset_i(reset_i), .send_i(send_i),
		.dest_i(dest_i), .sub_i(sub_i), .len_i(len_i), .prio_i(prio_i), .mode_i(mode_i),
		.startup_i(startup_i), .clear_faults_i(clear_faults_i),
		.hot_standby_i(hot_standby_i), .busy_o(busy_o), .word_i(word_i),
		.word_valid_i(word_valid_i), .word_ready_o(word_ready_o), .tx_data_o(tx_data_o),
		.tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready), .tx_last_o(tx_last_o),
		.rx_hdr_valid_i(rx_hdr_valid_i), .rx_func_i(rx_func_i), .rx_sub_i(rx_sub_i),
		.rx_accept_o(rx_accept_o), .rx_type_o(rx_type_o));
	peer_node u_peer (.clk_i(clk_i), .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o),
		.tx_last_i(tx_last_o), .stall_i(stall), .tx_ready_o(tx_ready));

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	// ==========================================
	// Checking and closing
	task automatic end_sim();
		if (err_count == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask
	// Bounded wait until the peer holds n bytes.
	task automatic wait_q(input int n);
		int t;
		t = 0;
		while (u_peer.q.size() < n && t < 2000) begin
			@(negedge clk_i);
			t++;
		end
		if (t == 2000) begin
			err_count++;
			end_sim();
		end
	endtask
	task automatic do_reset(input int c);
		reset_i = 1'b1;
		repeat (c) @(negedge clk_i);
		cmp("rst_busy", 8'h00, busy_o);
		cmp("rst_valid", 8'h00, tx_valid_o);
		cmp("rst_accept", 8'h00, rx_accept_o);
		reset_i = 1'b0;
	endtask
	// ==========================================
	// Stimulus
	// Each word is held until word_ready_o is seen before the taking edge.
	task automatic feed(input int nw, input byte_t b);
		int k;
		int t;
		for (k = 0; k < nw; k++) begin
			word_i = {byte_t'(b + 2 * k + 1), byte_t'(b + 2 * k)};
			word_valid_i = 1'b1;
			t = 0;
			while (word_ready_o !== 1'b1 && t < 2000) begin
				@(negedge clk_i);
				t++;
			end
			if (t == 2000) begin
				err_count++;
				end_sim();
			end
			@(negedge clk_i);
		end
		word_valid_i = 1'b0;
	endtask
	task automatic run_row(input row_t r);
		int n;
		int k;
		n = u_peer.frames;
		u_peer.q.delete();
		stall = r.st;
		sub_i = r.sub;
		dest_i = r.dest;
		len_i = r.len;
		prio_i = r.p;
		mode_i = r.m;
		send_i = 1'b1;
		fork
			feed(r.len / 2, r.b);
		join_none
		@(negedge clk_i);
		send_i = 1'b0;
		@(negedge clk_i);
		send_i = 1'b1;
		sub_i = 8'h2a;
		@(negedge clk_i);
		send_i = 1'b0;
		wait_q(6 + r.len);
		cmp("func", 8'h20, u_peer.q[0]);
		cmp("sub", r.sub, u_peer.q[1]);
		cmp("dest", r.edest, u_peer.q[2]);
		cmp("flags_lo", r.flo, u_peer.q[3]);
		cmp("len", r.len, u_peer.q[4]);
		cmp("flags_hi", 8'h01, u_peer.q[5]);
		for (k = 0; k < r.len; k++) begin
			cmp("content", byte_t'(r.b + k), u_peer.q[6 + k]);
		end
		cmp("last", 8'h01, 8'(u_peer.frames - n));
		cmp("busy", 8'h00, busy_o);
		cmp("extra", 8'h00, tx_valid_o);
	endtask
	task automatic internal(input logic [2:0] s, input byte_t sub, input byte_t edest);
		u_peer.q.delete();
		stall = 1'b0;
		prio_i = PRIO_NORMAL;
		dest_i = 8'h09;
		{startup_i, hot_standby_i, clear_faults_i} = s;
		@(negedge clk_i);
		{startup_i, hot_standby_i, clear_faults_i} = 3'b000;
		wait_q(6);
		cmp("ifunc", 8'h20, u_peer.q[0]);
		cmp("isub", sub, u_peer.q[1]);
		cmp("idest", edest, u_peer.q[2]);
		cmp("iflag", 8'h01, u_peer.q[5]);
	endtask
	initial begin
		{send_i, startup_i, clear_faults_i, hot_standby_i} = 4'h0;
		{word_valid_i, rx_hdr_valid_i, stall, word_i} = '0;
		{dest_i, sub_i, len_i, rx_func_i, rx_sub_i, lt} = '0;
		prio_i = PRIO_NORMAL;
		mode_i = MODE_DIRECTED;
		err_count = 0;
		checks_done = 0;
		do_reset(12);
		for (i = 0; i < 4; i++) begin
			run_row(rows[i]);
		end
		// Unknown function or subfunction leaves the last type untouched.
		for (i = 0; i < 6; i++) begin
			rx_func_i = rxr[i][15:8];
			rx_sub_i = rxr[i][7:0];
			rx_hdr_valid_i = 1'b1;
			@(negedge clk_i);
			rx_hdr_valid_i = 1'b0;
			if (rxr[i][16]) begin
				lt = rx_sub_i;
			end
			cmp("accept", {7'h00, rxr[i][16]}, rx_accept_o);
			cmp("type", lt, rx_type_o);
			@(negedge clk_i);
			cmp("accept_end", 8'h00, rx_accept_o);
		end
		internal(3'b101, 8'h00, 8'hff);
		cmp("ilen", 8'h00, u_peer.q[4]);
		cmp("ibusy", 8'h00, busy_o);
		do_reset(2);
		internal(3'b011, 8'h2d, 8'h1d);
		do_reset(2);
		internal(3'b001, 8'h13, 8'h09);
		do_reset(2);
		end_sim();
	end
endmodule
